// ---- core/esl_pkg.sv ----
package esl_pkg;
    // ****************************************
    // Access sizes and register map.
    // ****************************************
    localparam logic [1:0] SZ_BYTE   = 2'h0;
    localparam logic [1:0] SZ_WORD   = 2'h1;
    localparam logic [1:0] SZ_LONG   = 2'h2;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_INT  = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    // Control bit positions: three swap bits, two loopback enables.
    localparam int CTRL_BSB = 0;
    localparam int CTRL_NBS = 1;
    localparam int CTRL_WSW = 2;
    localparam int CTRL_LLB = 4;
    localparam int CTRL_RLB = 5;
    localparam logic [2:0] SWAP_RST = 3'h0;
    localparam logic [1:0] LOOP_RST = 2'h0;
    // Interrupt status bit positions.
    localparam int INT_LOST = 0;
    localparam int INT_UP   = 1;
    localparam int INT_ERR  = 2;
    localparam int INT_LOOP = 3;
    localparam logic [3:0] INT_RST  = 4'h0;
    localparam logic [3:0] ALL_LANE = 4'hF;
    // ****************************************
    // Timing.
    // ****************************************
    localparam int CLK_MHZ         = 125;
    localparam int LINK_RECOVER_US = 1000;
    localparam int LINK_RECOVER_CYC = LINK_RECOVER_US * CLK_MHZ;
    typedef logic [23:0] esl_cnt_t;

    // Lane index xor applied to every byte lane for a given size and setting.
    function automatic logic [1:0] lane_xor(input logic [1:0] size,
                                            input logic [2:0] swapCfg);
        logic [1:0] sel;
        sel = 2'h0;
        // RULE1 RULE2 RULE3 RULE14 RULE15 RULE16 lane select
        case (size)
            SZ_BYTE: sel = {1'b0, !swapCfg[CTRL_BSB]};
            SZ_WORD: sel = {swapCfg[CTRL_WSW], !swapCfg[CTRL_NBS]};
            default: sel = swapCfg[CTRL_NBS] ? 2'h0 : 2'h3;
        endcase
        return sel;
    endfunction : lane_xor
endpackage : esl_pkg

// ---- core/esl_lane_swap.sv ----
`timescale 1ns/1ps
module esl_lane_swap (
    input  wire logic        clk_sys,  // System clock.
    input  wire logic        rst_b,    // Async reset, low.
    input  wire logic        inValid,  // Input beat valid.
    input  wire logic [1:0]  inSize,   // Access size.
    input  wire logic [2:0]  swapCfg,  // Swap settings.
    input  wire logic [31:0] inData,   // Source lanes.
    input  wire logic [3:0]  inBe,     // Source enables.
    output logic             outValid, // Steered beat valid.
    output logic [31:0]      outData,  // Steered lanes.
    output logic [3:0]       outBe     // Steered enables.
);
    wire  [1:0]  laneSel = esl_pkg::lane_xor(inSize, swapCfg);
    logic [31:0] steerData;
    logic [3:0]  steerBe;

    // Each destination lane picks the source lane at index xor laneSel.
    for (genvar j = 0; j < 4; j++) begin : gLane
        wire [1:0] srcLane = 2'(j) ^ laneSel;
        assign steerData[8*j +: 8] = inData[8*srcLane +: 8];
        assign steerBe[j]          = inBe[srcLane];
    end

    // Registers the steered beat.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            outValid <= 1'b0;
            outData  <= 32'h0000_0000;
            outBe    <= 4'h0;
        end else begin
            outValid <= inValid;
            outData  <= steerData;
            outBe    <= steerBe;
        end
    end
endmodule : esl_lane_swap

// ---- core/esl_link_mon.sv ----
`timescale 1ns/1ps
module esl_link_mon #(
    parameter int RECOVER_CYC = esl_pkg::LINK_RECOVER_CYC
) (
    input  wire logic clk_sys,     // System clock.
    input  wire logic rst_b,       // Async reset, low.
    input  wire logic loopChange,  // Loopback setting changed.
    input  wire logic xcvrOkPin,   // Transceiver link good pin.
    input  wire logic fiberErrPin, // Fiber data error pin.
    output logic      linkUp,      // Link good flag.
    output logic      linkLost,    // Pulse on link drop.
    output logic      linkBack,    // Pulse on link return.
    output logic      fiberErr     // Pulse on data error.
);
    logic [1:0]        okSync;
    logic [2:0]        errSync;
    esl_pkg::esl_cnt_t cntQ;
    wire               recovering = (cntQ != '0);
    // RULE8 forced link drop
    wire linkUpD = okSync[1] && !recovering && !loopChange;

    // Synchronises the pins and times the transceiver recovery.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            okSync   <= 2'h0;
            errSync  <= 3'h0;
            cntQ     <= '0;
            linkUp   <= 1'b0;
            linkLost <= 1'b0;
            linkBack <= 1'b0;
            fiberErr <= 1'b0;
        end else begin
            okSync   <= {okSync[0], xcvrOkPin};
            errSync  <= {errSync[1:0], fiberErrPin};
            if (loopChange) begin
                cntQ <= esl_pkg::esl_cnt_t'(RECOVER_CYC);
            end else if (recovering) begin
                cntQ <= cntQ - 1'b1;
            end
            linkUp   <= linkUpD;
            linkLost <= linkUp && !linkUpD;
            linkBack <= !linkUp && linkUpD;
            // RULE10 error edge detect
            fiberErr <= errSync[1] && !errSync[2];
        end
    end
endmodule : esl_link_mon

// ---- core/esl_core.sv ----
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Longword lanes reversed with no swap bits.
// RULE2 - Non-byte swap keeps longword lanes unchanged.
// RULE3 - Byte swap and word swap ignore longwords.
// RULE4 - Separate local and remote loopback enable bits.
// RULE5 - Local loopback turns path on own card.
// RULE6 - Fiber wrap: transmit with remote loop on.
// RULE7 - Remote loopback turns path on remote card.
// RULE8 - Loopback change drops link good flag.
// RULE9 - Host polls link good up to 1.5 s.
// RULE10 - Fiber data errors logged in status.
// RULE11 - Host activates mapping before loopback traffic.
// RULE12 - Host reinitialises after loopback is off.
// RULE13 - Host never swaps loop kinds in one write.
// RULE14 - Byte swap keeps byte lanes in place.
// RULE15 - Word swap moves word to other half.
// RULE16 - Non-byte swap keeps word byte order.
// RULE17 - Read data uses the inverse lane mapping.
module esl_core #(
    parameter int RECOVER_CYC = esl_pkg::LINK_RECOVER_CYC
) (
    input  wire logic        clk_sys,       // System clock.
    input  wire logic        rst_b,         // Async reset, low.
    input  wire logic        hsel,          // AHB select.
    input  wire logic [31:0] haddr,         // AHB address.
    input  wire logic [1:0]  htrans,        // AHB transfer type.
    input  wire logic        hwrite,        // AHB write.
    input  wire logic [2:0]  hsize,         // AHB size.
    input  wire logic [31:0] hwdata,        // AHB write data.
    input  wire logic        hready,        // AHB ready in.
    output logic             hreadyout,     // AHB ready out.
    output logic             hresp,         // AHB response.
    output logic [31:0]      hrdata,        // AHB read data.
    input  wire logic        pciValid,      // Host access request.
    input  wire logic        pciWrite,      // Host access is write.
    input  wire logic [1:0]  pciSize,       // Host access size.
    input  wire logic [3:0]  pciBe,         // Host byte enables.
    input  wire logic [31:0] pciWdata,      // Host write data.
    output logic             pciRdValid,    // Read data valid.
    output logic [31:0]      pciRdata,      // Read data.
    output logic             txValid,       // Fiber request valid.
    output logic             txWrite,       // Fiber request is write.
    output logic [31:0]      txData,        // Fiber request data.
    output logic [3:0]       txBe,          // Fiber byte enables.
    input  wire logic        rxValid,       // Fiber read return.
    input  wire logic [31:0] rxData,        // Fiber read data.
    input  wire logic        farLoopLocal,  // Far side local loop.
    input  wire logic        farLoopRemote, // Far side remote loop.
    output logic             remoteLoopEn,  // Remote loop to far card.
    input  wire logic        xcvrOkPin,     // Transceiver good pin.
    input  wire logic        fiberErrPin,   // Fiber error pin.
    output logic             linkUp,        // Link good flag.
    output logic             irq            // Interrupt, high.
);
    // ****************************************
    // Register bus slave.
    // ****************************************
    logic        wrPendQ;
    logic [7:0]  addrQ;
    logic [2:0]  swapQ;
    logic [1:0]  loopQ;
    logic [3:0]  intStatQ;
    logic [3:0]  maskQ;
    logic [1:0]  loopPrevQ;
    logic        wrQ;
    logic [1:0]  rdSizeQ;
    logic        loopRdQ;
    logic [31:0] loopDataQ;
    logic        swValid;
    logic [31:0] swData;
    logic        linkLost;
    logic        linkBack;
    logic        fiberErr;

    // Address phase decode and data phase write strobes.
    wire addrPhase = hsel && htrans[1] && hready;
    wire rdPhase   = addrPhase && !hwrite;
    wire wrCtrl    = wrPendQ && (addrQ == esl_pkg::ADDR_CTRL);
    wire wrInt     = wrPendQ && (addrQ == esl_pkg::ADDR_INT);
    wire wrMask    = wrPendQ && (addrQ == esl_pkg::ADDR_MASK);

    // Next register values, also used for read forwarding.
    wire [2:0] swapD = wrCtrl ? hwdata[esl_pkg::CTRL_WSW:esl_pkg::CTRL_BSB] : swapQ;
    // RULE4 independent loop bits
    wire [1:0] loopD = wrCtrl ? hwdata[esl_pkg::CTRL_RLB:esl_pkg::CTRL_LLB] : loopQ;
    wire [3:0] maskD = wrMask ? hwdata[3:0] : maskQ;

    // Loopback state seen from both sides of the adapter.
    wire localLoop  = loopQ[0] || farLoopLocal;
    wire remoteLoop = loopQ[1] || farLoopRemote;
    wire [1:0] loopEff = {remoteLoop, localLoop};
    wire loopChange = (loopEff != loopPrevQ);

    // Events set status bits; a set beats a clear in the same cycle.
    wire [3:0] intEvt  = {loopChange, fiberErr, linkBack, linkLost};
    wire [3:0] intClr  = wrInt ? hwdata[3:0] : 4'h0;
    wire [3:0] intStatD = (intStatQ & ~intClr) | intEvt;

    // Read mux over forwarded next values, except status which reads current values; unmapped reads return zero.
    wire [31:0] ctrlRd = {26'h000_0000, loopD, 1'b0, swapD};
    wire [31:0] statRd = {29'h0000_0000, remoteLoop, localLoop, linkUp};
    wire [31:0] rdMux  =
        (haddr[7:0] == esl_pkg::ADDR_CTRL) ? ctrlRd :
        (haddr[7:0] == esl_pkg::ADDR_STAT) ? statRd :
        (haddr[7:0] == esl_pkg::ADDR_INT)  ? {28'h000_0000, intStatD} :
        (haddr[7:0] == esl_pkg::ADDR_MASK) ? {28'h000_0000, maskD} :
        32'h0000_0000;

    // The slave answers with no wait state and always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Bus phase tracking and read data register.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wrPendQ <= 1'b0;
            addrQ   <= 8'h00;
            hrdata  <= 32'h0000_0000;
        end else begin
            wrPendQ <= addrPhase && hwrite;
            addrQ   <= haddr[7:0];
            if (rdPhase) begin
                hrdata <= rdMux;
            end
        end
    end

    // Control, mask and interrupt status registers.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            swapQ     <= esl_pkg::SWAP_RST;
            loopQ     <= esl_pkg::LOOP_RST;
            maskQ     <= esl_pkg::INT_RST;
            intStatQ  <= esl_pkg::INT_RST;
            loopPrevQ <= esl_pkg::LOOP_RST;
        end else begin
            swapQ     <= swapD;
            loopQ     <= loopD;
            maskQ     <= maskD;
            // RULE10 error logged sticky
            intStatQ  <= intStatD;
            loopPrevQ <= loopEff;
        end
    end

    // Interrupt is high while any unmasked status bit is set.
    assign irq = |(intStatQ & maskQ);

    // ****************************************
    // Data path and loopback.
    // ****************************************
    // RULE1 write lane steering
    esl_lane_swap uTxSwap (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .inValid  (pciValid),
        .inSize   (pciSize),
        .swapCfg  (swapQ),
        .inData   (pciWdata),
        .inBe     (pciBe),
        .outValid (swValid),
        .outData  (swData),
        .outBe    (txBe)
    );
    assign txData = swData;

    // RULE5 local loop blocks fiber
    assign txValid = swValid && !localLoop;

    // Remembers direction, read size and the local loop store.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wrQ       <= 1'b0;
            rdSizeQ   <= esl_pkg::SZ_LONG;
            loopRdQ   <= 1'b0;
            loopDataQ <= 32'h0000_0000;
            remoteLoopEn <= 1'b0;
        end else begin
            wrQ <= pciWrite;
            if (pciValid && !pciWrite) begin
                rdSizeQ <= pciSize;
            end
            // RULE5 turn path on card
            loopRdQ <= swValid && !wrQ && localLoop;
            if (swValid && wrQ && localLoop) begin
                loopDataQ <= swData;
            end
            // RULE7 loop at remote card
            remoteLoopEn <= loopQ[1];
        end
    end
    assign txWrite = wrQ;

    // Read return comes from the fiber, or from the local store.
    wire        rdSelValid = localLoop ? loopRdQ : rxValid;
    wire [31:0] rdSelData  = localLoop ? loopDataQ : rxData;

    // RULE17 inverse read steering
    esl_lane_swap uRxSwap (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .inValid  (rdSelValid),
        .inSize   (rdSizeQ),
        .swapCfg  (swapQ),
        .inData   (rdSelData),
        .inBe     (esl_pkg::ALL_LANE),
        .outValid (pciRdValid),
        .outData  (pciRdata),
        .outBe    ()
    );

    // RULE8 link recovery timing
    esl_link_mon #(
        .RECOVER_CYC (RECOVER_CYC)
    ) uLinkMon (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .loopChange  (loopChange),
        .xcvrOkPin   (xcvrOkPin),
        .fiberErrPin (fiberErrPin),
        .linkUp      (linkUp),
        .linkLost    (linkLost),
        .linkBack    (linkBack),
        .fiberErr    (fiberErr)
    );

    // ****************************************
    // Checks.
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    wire longReq = pciValid && (pciSize == esl_pkg::SZ_LONG);
    wire wordReq = pciValid && (pciSize == esl_pkg::SZ_WORD);
    wire nbs     = swapQ[esl_pkg::CTRL_NBS];
    wire wsw     = swapQ[esl_pkg::CTRL_WSW];
    wire bsb     = swapQ[esl_pkg::CTRL_BSB];

    // RULE1 longword reversal check
    long_reverse_a: assert property (longReq && !nbs && !bsb && !wsw |=> txData ==
        {$past(pciWdata[7:0]), $past(pciWdata[15:8]),
         $past(pciWdata[23:16]), $past(pciWdata[31:24])})
        else $error("Longword lanes not reversed.");
    // RULE2 longword kept check
    long_keep_a: assert property (longReq && nbs |=> txData == $past(pciWdata))
        else $error("Longword lanes changed under non-byte swap.");
    // RULE3 swap bits ignored
    long_ignore_a: assert property (longReq && !nbs && bsb && wsw |=>
        txData[31:24] == $past(pciWdata[7:0]) && txData[7:0] == $past(pciWdata[31:24]))
        else $error("Longword mapping altered by byte or word swap.");
    // RULE14 byte lane kept
    byte_keep_a: assert property (pciValid && pciSize == esl_pkg::SZ_BYTE && bsb
        |=> txData == $past(pciWdata) && txBe == $past(pciBe))
        else $error("Byte access moved under byte swap.");
    // RULE15 word exchange check
    word_xchg_a: assert property (wordReq && wsw && !nbs |=>
        txData[31:24] == $past(pciWdata[7:0]) && txData[23:16] == $past(pciWdata[15:8]))
        else $error("Word not moved to other half.");
    // RULE16 word order kept
    word_keep_a: assert property (wordReq && nbs && !wsw |=>
        txData[15:0] == $past(pciWdata[15:0]))
        else $error("Word byte order changed under non-byte swap.");
    // RULE17 read inverse check
    read_inverse_a: assert property (rxValid && !localLoop && !nbs &&
        rdSizeQ == esl_pkg::SZ_LONG |=> pciRdValid &&
        pciRdata == {$past(rxData[7:0]), $past(rxData[15:8]),
                     $past(rxData[23:16]), $past(rxData[31:24])})
        else $error("Read data not inversely steered.");
    // RULE5 local loop return
    local_loop_a: assert property (localLoop && pciValid && !pciWrite && $stable(localLoop)
        |=> !txValid ##2 pciRdValid)
        else $error("Local loopback did not turn the path.");
    // RULE6 remote loop transmits
    remote_tx_a: assert property (remoteLoop && !localLoop && pciValid |=> txValid)
        else $error("Remote loopback did not transmit.");
    // RULE8 link drop check
    link_drop_a: assert property (loopChange |=> !linkUp ##1 intStatQ[esl_pkg::INT_LOOP])
        else $error("Link good did not drop on loop change.");
    // RULE10 error logging check
    err_log_a: assert property (fiberErr |=> intStatQ[esl_pkg::INT_ERR])
        else $error("Fiber error not logged.");
    // RULE4 loop bits written
    loop_bits_a: assert property (wrCtrl |=> loopQ == $past(hwdata[5:4]))
        else $error("Loop enables not taken from write.");
endmodule : esl_core

// ---- tb/esl_far_card.sv ----
`timescale 1ns/1ps
module esl_far_card #(
    parameter int DROP_CYC = 8 // Far transceiver recovery time in cycles.
) (
    input  wire logic        clk_sys,      // System clock.
    input  wire logic        rst_b,        // Async reset, low.
    input  wire logic        txValid,      // Request valid.
    input  wire logic        txWrite,      // Request is write.
    input  wire logic [31:0] txData,       // Request data.
    input  wire logic [3:0]  txBe,         // Request enables.
    input  wire logic        remoteLoopEn, // Remote loop request.
    output logic             rxValid,      // Read return.
    output logic [31:0]      rxData,       // Read data.
    output logic             xcvrOkPin,    // Link good.
    output logic             fiberErrPin   // Data error.
);
    logic [31:0] memQ;
    logic [2:0]  latQ;
    logic        slowQ;
    logic        loopQ;
    logic [7:0]  dropQ;
    // ****************************************
    // Far memory and read return.
    // ****************************************
    // Stores enabled lanes and answers reads alternately fast and slow.
    // data turned back
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            memQ <= 32'h0000_0000;
            latQ <= 3'h0;
            slowQ <= 1'b0;
            rxValid <= 1'b0;
            rxData <= 32'h0000_0000;
        end else begin
            for (int j = 0; j < 4; j++) begin
                if (txValid && txWrite && txBe[j]) memQ[8*j +: 8] <= txData[8*j +: 8];
            end
            if (txValid && !txWrite) begin
                latQ <= slowQ ? 3'h4 : 3'h1;
                slowQ <= !slowQ;
            end else if (latQ != 3'h0) begin
                latQ <= latQ - 3'h1;
            end
            rxValid <= (latQ == 3'h1);
            rxData <= (latQ == 3'h1) ? memQ : ~rxData; // Data toggles between releases.
        end
    end
    // ****************************************
    // Transceiver recovery.
    // ****************************************
    // A remote loop change acts like a cable replug: link good drops, an error shows.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            loopQ <= 1'b0;
            dropQ <= 8'h00;
            xcvrOkPin <= 1'b0;
            fiberErrPin <= 1'b0;
        end else begin
            loopQ <= remoteLoopEn;
            if (remoteLoopEn != loopQ) dropQ <= 8'(DROP_CYC);
            else if (dropQ != 8'h00) dropQ <= dropQ - 8'h01;
            xcvrOkPin <= (dropQ == 8'h00) && (remoteLoopEn == loopQ);
            fiberErrPin <= (dropQ == 8'h02);
        end
    end
endmodule : esl_far_card

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b, m) begin totalChecks++; if ((a) !== (b)) begin errCount++; \
    $display("MISMATCH %0t %s", $time, m); end end
module tb;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b1;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        hreadyout, hresp, pciRdValid, txValid, txWrite, remoteLoopEn;
    logic        rxValid, xcvrOkPin, fiberErrPin, linkUp, irq;
    logic [31:0] hrdata, pciRdata, txData, rxData;
    logic [3:0]  txBe;
    logic        pciValid = 1'b0;
    logic        pciWrite = 1'b0;
    logic [1:0]  pciSize = 2'h0;
    logic [3:0]  pciBe = 4'h0;
    logic [31:0] pciWdata = 32'h0000_0000;
    logic        farLoopLocal = 1'b0;
    logic        farLoopRemote = 1'b0;
    int          errCount = 0;
    int          totalChecks = 0;
    int          cyc = 0;
    logic [31:0] rd;

    // Clock, and a cycle ceiling against hangs.
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            errCount++;
            tallyAndFinish();
        end
    end

    esl_core #(.RECOVER_CYC(20)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pciValid(pciValid), .pciWrite(pciWrite), .pciSize(pciSize), .pciBe(pciBe),
        .pciWdata(pciWdata), .pciRdValid(pciRdValid), .pciRdata(pciRdata),
        .txValid(txValid), .txWrite(txWrite), .txData(txData), .txBe(txBe),
        .rxValid(rxValid), .rxData(rxData), .farLoopLocal(farLoopLocal),
        .farLoopRemote(farLoopRemote), .remoteLoopEn(remoteLoopEn), .xcvrOkPin(xcvrOkPin),
        .fiberErrPin(fiberErrPin), .linkUp(linkUp), .irq(irq));
    esl_far_card far (.clk_sys(clk_sys), .rst_b(rst_b), .txValid(txValid),
        .txWrite(txWrite), .txData(txData), .txBe(txBe), .remoteLoopEn(remoteLoopEn),
        .rxValid(rxValid), .rxData(rxData), .xcvrOkPin(xcvrOkPin),
        .fiberErrPin(fiberErrPin));

    // ****************************************
    // Bus and host access tasks.
    // ****************************************
    task automatic waitRdy();
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
    endtask : waitRdy

    task automatic busWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        #1;
    endtask : busWr

    task automatic busRd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        waitRdy();
        htrans <= 2'h0;
        waitRdy();
        d = hrdata;
    endtask : busRd

    task automatic pciBeat(input logic w, input logic [1:0] s, input logic [3:0] b,
                           input logic [31:0] d);
        @(posedge clk_sys);
        pciValid <= 1'b1;
        pciWrite <= w;
        pciSize <= s;
        pciBe <= b;
        pciWdata <= d;
        @(posedge clk_sys);
        pciValid <= 1'b0;
        #1;
    endtask : pciBeat

    // Expected lane xor for a size and swap setting.
    function automatic logic [1:0] expX(input logic [2:0] c, input logic [1:0] s);
        if (s == 2'h0) return c[0] ? 2'h0 : 2'h1;
        if (s == 2'h1) return {c[2], !c[1]};
        return c[1] ? 2'h0 : 2'h3;
    endfunction : expX

    // Moves source lane j^x into destination lane j.
    function automatic logic [35:0] steer(input logic [35:0] v, input logic [1:0] x);
        for (int j = 0; j < 4; j++) begin
            steer[8*j +: 8] = v[8*(j ^ x) +: 8];
            steer[32 + j] = v[32 + (j ^ x)];
        end
    endfunction : steer

    // Writes one beat, checks what leaves, reads it back and checks lanes.
    task automatic roundTrip(input logic [1:0] s, input logic [3:0] b, input logic [2:0] c,
                             input logic tx, input logic [31:0] d);
        logic [31:0] m;
        int          n;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        pciBeat(1'b1, s, b, d);
        `CHK(txValid, tx, "tx valid")
        if (tx) `CHK({txBe, txData}, steer({b, d}, expX(c, s)), "tx lanes")
        pciBeat(1'b0, s, b, 32'h0000_0000);
        n = 0;
        while (pciRdValid !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        `CHK(pciRdValid, 1'b1, "read return")
        `CHK(pciRdata & m, d & m, "read lanes")
    endtask : roundTrip

    // Changes a loop setting, watches the link drop, polls it back, checks status.
    task automatic loopGo(input logic fr, input logic [31:0] c, input logic [3:0] ei,
                          input logic [2:0] es);
        int n;
        busWr(esl_pkg::ADDR_INT, 32'h0000_000F);
        if (fr) begin
            @(posedge clk_sys);
            farLoopLocal <= c[4];
        end else begin
            busWr(esl_pkg::ADDR_CTRL, c);
        end
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK(linkUp, 1'b0, "link drop")
        `CHK(irq, 1'b1, "irq raise")
        `CHK(remoteLoopEn, c[5] & !fr, "remote enable")
        n = 0;
        do begin
            busRd(esl_pkg::ADDR_STAT, rd);
            n++;
        end while (rd[0] !== 1'b1 && n < 100);
        `CHK(rd, {29'h0, es}, "status")
        busRd(esl_pkg::ADDR_INT, rd);
        `CHK(rd, {28'h0, ei}, "int status")
    endtask : loopGo

    task automatic tallyAndFinish();
        if (errCount == 0 && totalChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tallyAndFinish

    // ****************************************
    // Test sequence.
    // ****************************************
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk_sys);
        busRd(esl_pkg::ADDR_CTRL, rd);
        `CHK(rd, 32'h0000_0000, "ctrl reset")
        busRd(esl_pkg::ADDR_MASK, rd);
        `CHK(rd, 32'h0000_0000, "mask reset")
        busRd(esl_pkg::ADDR_INT, rd);
        `CHK(rd, 32'h0000_0002, "link back event")
        busWr(esl_pkg::ADDR_INT, 32'h0000_0002);
        busRd(esl_pkg::ADDR_INT, rd);
        `CHK(rd, 32'h0000_0000, "int clear")
        busWr(8'h10, 32'hFFFF_FFFF);
        busRd(8'h10, rd);
        `CHK(rd, 32'h0000_0000, "unmapped")
        // Every swap setting against every access size.
        for (int c = 0; c < 8; c++) begin
            busWr(esl_pkg::ADDR_CTRL, {29'h0, 3'(c)});
            roundTrip(2'h0, 4'h1, 3'(c), 1'b1, 32'h4433_2211);
            roundTrip(2'h1, 4'h3, 3'(c), 1'b1, 32'h8877_6655);
            roundTrip(2'h2, 4'hF, 3'(c), 1'b1, 32'h1234_5678 + 32'(c));
        end
        busWr(esl_pkg::ADDR_CTRL, 32'h0000_0000);
        busWr(esl_pkg::ADDR_MASK, 32'h0000_000F);
        loopGo(1'b0, 32'h0000_0020, 4'hF, 3'h5);
        roundTrip(2'h2, 4'hF, 3'h0, 1'b1, 32'hCAFE_0123);
        busWr(esl_pkg::ADDR_MASK, 32'h0000_0000);
        `CHK(irq, 1'b0, "irq masked")
        busWr(esl_pkg::ADDR_MASK, 32'h0000_000F);
        `CHK(irq, 1'b1, "irq unmasked")
        busWr(esl_pkg::ADDR_INT, 32'h0000_000F);
        `CHK(irq, 1'b0, "irq cleared")
        // Off and on go in separate writes, with a fresh start between.
        loopGo(1'b0, 32'h0000_0000, 4'hF, 3'h1);
        loopGo(1'b0, 32'h0000_0010, 4'hB, 3'h3);
        roundTrip(2'h2, 4'hF, 3'h0, 1'b0, 32'hA5C3_0F96);
        loopGo(1'b0, 32'h0000_0000, 4'hB, 3'h1);
        loopGo(1'b1, 32'h0000_0010, 4'hB, 3'h3);
        roundTrip(2'h1, 4'h3, 3'h0, 1'b0, 32'h0000_BEEF);
        loopGo(1'b1, 32'h0000_0000, 4'hB, 3'h1);
        roundTrip(2'h2, 4'hF, 3'h0, 1'b1, 32'h0102_0304);
        tallyAndFinish();
    end
endmodule : tb
